/* rtl/dsld_pkg.sv */
/*
 * Shared types and constants of the DRAM strobe and lane block.
 * Assumes a single 40 MHz clock domain; no software-visible registers.
 */
package dsld_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int NUM_BANKS = 2;
    localparam int CAS_LANES = 4;
    localparam int ADDR_W = 28;
    localparam int DED_ADDR_W = 24;
    localparam int OPT_ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int COL_BITS = 10;
    localparam int TIM_W = 2;
    localparam real CLK_PERIOD_NS = 25.0;

    // ------------------------------------------------------------------
    // Reset values of pin-side state and the phase timer
    // ------------------------------------------------------------------
    localparam logic [NUM_BANKS-1:0] RAS_OFF = 2'h3;
    localparam logic [CAS_LANES-1:0] CAS_OFF = 4'hf;
    localparam logic [ADDR_W-1:0] ADDR_RST = 28'h000_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [TIM_W-1:0] CNT_RST = 2'h0;

    // Operand size as driven on the transfer size pins
    typedef enum logic [1:0] {
        SZ_LONG = 2'h0,
        SZ_BYTE = 2'h1,
        SZ_WORD = 2'h2,
        SZ_LINE = 2'h3
    } dsld_size_t;

    // Port width of a bank; code 3 decodes as 32-bit
    typedef enum logic [1:0] {
        PORT_8 = 2'h0,
        PORT_16 = 2'h1,
        PORT_32 = 2'h2,
        PORT_RSV = 2'h3
    } dsld_port_t;

    // Strobe timing configuration; each TIM_W-wide field adds that many cycles
    typedef struct packed {
        logic ext_master_addr_mux_enable;
        logic [TIM_W-1:0] ras_cas_gap;
        logic [TIM_W-1:0] cas_width;
        logic [TIM_W-1:0] precharge;
    } dsld_timing_t;

    // One DRAM transfer request
    typedef struct packed {
        logic bank;
        logic write;
        logic ext;
        dsld_size_t size;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dsld_req_t;

    // Sequencer states, Gray coded along idle-row-column-precharge
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ROW = 3'h1,
        ST_COL = 3'h3,
        ST_PRE = 3'h2,
        ST_RCAS = 3'h6,
        ST_RRAS = 3'h7
    } dsld_state_t;

endpackage

/* rtl/dsld_cas_decode.sv */
/*
 * Column strobe lane decoder: operand size, port width and A[1:0]
 * to one enable per byte lane, plus the first lane in use.
 * Assumes lane 0 is D[31:24] and narrow ports sit on the upper lanes.
 */
`timescale 1ns/10ps
module dsld_cas_decode (
    input wire dsld_pkg::dsld_size_t size,
    input wire dsld_pkg::dsld_port_t port,
    input wire logic [1:0] a_low,
    output logic [dsld_pkg::CAS_LANES-1:0] cas_en,
    output logic [1:0] lane
);
    import dsld_pkg::*;

    // ------------------------------------------------------------------
    // Port and operand classification
    // ------------------------------------------------------------------
    wire p8 = (port == PORT_8);
    wire p16 = (port == PORT_16);
    wire is_byte = (size == SZ_BYTE);
    wire is_word = (size == SZ_WORD);

    // First lane: byte follows A[0] or A[1:0], word follows A[1]
    wire [1:0] lane16 = is_byte ? {1'b0, a_low[0]} : 2'h0;
    wire [1:0] lane32 = is_byte ? a_low : (is_word ? {a_low[1], 1'b0} : 2'h0);
    assign lane = p8 ? 2'h0 : (p16 ? lane16 : lane32);

    // Lane count: one on 8-bit, at most two on 16-bit, up to four
    wire [2:0] n16 = is_byte ? 3'h1 : 3'h2;
    wire [2:0] n32 = is_byte ? 3'h1 : (is_word ? 3'h2 : 3'h4);
    wire [2:0] nlanes = p8 ? 3'h1 : (p16 ? n16 : n32);
    wire [2:0] lane_end = {1'b0, lane} + nlanes;

    // ------------------------------------------------------------------
    // One enable per lane, lane i covers its own byte of D
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < CAS_LANES; i++) begin : g_lane
            assign cas_en[i] = (3'(i) >= {1'b0, lane}) &&
                               (3'(i) < lane_end);
        end
    endgenerate

endmodule

/* rtl/dsld_strobe_ctrl.sv */
/*
 * DRAM strobe sequencer: row and column strobes, write strobe,
 * transfer size, row/column address multiplex and byte-lane steering.
 * Assumes bank decode, refresh timing and permission checks are done
 * upstream; requests and refresh pulses are synchronous to clk.
 */
`timescale 1ns/10ps
module dsld_strobe_ctrl #(
    parameter int COL_SHIFT = dsld_pkg::COL_BITS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire dsld_pkg::dsld_req_t req,
    output logic req_ready,
    input wire dsld_pkg::dsld_port_t [dsld_pkg::NUM_BANKS-1:0] bank_port,
    input wire dsld_pkg::dsld_timing_t strobe_timing_register,
    input wire logic [dsld_pkg::OPT_ADDR_W-1:0] pin_assignment_register,
    input wire logic refresh_req,
    output logic done,
    output logic [dsld_pkg::DATA_W-1:0] rdata,
    output logic [dsld_pkg::NUM_BANKS-1:0] ras_n,
    output logic [dsld_pkg::CAS_LANES-1:0] cas_n,
    output logic mem_write_strobe_n,
    output logic [1:0] transfer_size,
    output logic [dsld_pkg::ADDR_W-1:0] addr_out,
    output logic [dsld_pkg::ADDR_W-1:0] addr_oe_n,
    output logic [dsld_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n,
    input wire logic [dsld_pkg::DATA_W-1:0] data_in
);
    import dsld_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dsld_state_t state_r, state_nxt;
    dsld_req_t cur_r;
    dsld_req_t cur_nxt;
    logic [TIM_W-1:0] cnt_r, cnt_nxt;
    logic pend_r, pend_nxt;
    logic [NUM_BANKS-1:0] ras_n_r, ras_n_nxt;
    logic [CAS_LANES-1:0] cas_n_r, cas_n_nxt;
    logic we_n_r, we_n_nxt;
    logic [1:0] tsize_r;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [ADDR_W-1:0] aoe_r, aoe_nxt;
    logic [DATA_W-1:0] dout_r, dout_nxt;
    logic doe_r, doe_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic done_r, done_nxt;
    logic [CAS_LANES-1:0] cas_en_nxt;
    logic [1:0] lane_nxt;
    logic [CAS_LANES-1:0] cas_en_cur;
    logic [1:0] lane_cur;

    // ------------------------------------------------------------------
    // Request acceptance and refresh arbitration
    // ------------------------------------------------------------------
    // Refresh wins over a waiting transfer at idle
    wire idle = (state_r == ST_IDLE);
    wire ref_want = pend_r | refresh_req;
    wire ref_start = idle & ref_want;
    assign req_ready = idle & ~ref_want;
    wire take = req_valid & req_ready;
    assign cur_nxt = take ? req : cur_r;
    // A refresh pulse landing on the consuming cycle is kept pending
    assign pend_nxt = ref_start ? (pend_r & refresh_req) : ref_want;

    // Phase timer expires when it reaches zero
    wire last = (cnt_r == CNT_RST);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Access runs row, column, precharge; refresh runs column then row
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (ref_start) begin
                    state_nxt = ST_RCAS;
                end else if (take) begin
                    state_nxt = ST_ROW;
                end
            end
            ST_ROW: begin
                if (last) begin
                    state_nxt = ST_COL;
                end
            end
            ST_COL: begin
                if (last) begin
                    state_nxt = ST_PRE;
                end
            end
            ST_RCAS: begin
                if (last) begin
                    state_nxt = ST_RRAS;
                end
            end
            ST_RRAS: begin
                if (last) begin
                    state_nxt = ST_PRE;
                end
            end
            ST_PRE: begin
                if (last) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Phase length loaded on entry from the timing fields
    wire moving = (state_nxt != state_r);
    wire nxt_row = (state_nxt == ST_ROW);
    wire nxt_col = (state_nxt == ST_COL);
    wire nxt_rcas = (state_nxt == ST_RCAS);
    wire nxt_rras = (state_nxt == ST_RRAS);
    wire nxt_pre = (state_nxt == ST_PRE);
    wire [TIM_W-1:0] load_val =
        (nxt_row | nxt_rcas) ? strobe_timing_register.ras_cas_gap :
        (nxt_col | nxt_rras) ? strobe_timing_register.cas_width :
        nxt_pre ? strobe_timing_register.precharge : CNT_RST;
    assign cnt_nxt = moving ? load_val :
                     (last ? CNT_RST : cnt_r - 2'h1);

    // ------------------------------------------------------------------
    // Lane decode for the next and the current transfer
    // ------------------------------------------------------------------
    dsld_cas_decode u_dec_nxt (
        .size(cur_nxt.size),
        .port(bank_port[cur_nxt.bank]),
        .a_low(cur_nxt.addr[1:0]),
        .cas_en(cas_en_nxt),
        .lane(lane_nxt)
    );

    dsld_cas_decode u_dec_cur (
        .size(cur_r.size),
        .port(bank_port[cur_r.bank]),
        .a_low(cur_r.addr[1:0]),
        .cas_en(cas_en_cur),
        .lane(lane_cur)
    );

    // ------------------------------------------------------------------
    // Strobe and write strobe decode from the next state
    // ------------------------------------------------------------------
    wire acc_nxt = nxt_row | nxt_col;
    wire ref_nxt = nxt_rcas | nxt_rras;
    wire [NUM_BANKS-1:0] bank_oh = cur_nxt.bank ? 2'h2 : 2'h1;
    // Only the addressed bank, or both banks in the refresh row phase
    assign ras_n_nxt = ~(({NUM_BANKS{acc_nxt}} & bank_oh) |
                         {NUM_BANKS{nxt_rras}});
    assign cas_n_nxt = ~(({CAS_LANES{nxt_col}} & cas_en_nxt) |
                         {CAS_LANES{ref_nxt}});
    // Write strobe tracks only DRAM writes, never the bus direction
    assign we_n_nxt = ~(acc_nxt & cur_nxt.write);

    // ------------------------------------------------------------------
    // Address multiplex
    // ------------------------------------------------------------------
    wire mux_on = ~cur_nxt.ext |
                  strobe_timing_register.ext_master_addr_mux_enable;
    wire [ADDR_W-1:0] row_addr = cur_nxt.addr >> COL_SHIFT;
    wire [ADDR_W-1:0] col_addr = ADDR_W'(cur_nxt.addr[COL_SHIFT-1:0]);
    assign addr_nxt = ~mux_on ? cur_nxt.addr :
                      (nxt_row ? row_addr :
                      (nxt_col ? col_addr : cur_nxt.addr));
    assign aoe_nxt = {ADDR_W{~(acc_nxt & mux_on)}};

    // ------------------------------------------------------------------
    // Data steering onto the upper lanes
    // ------------------------------------------------------------------
    // Replicated so an 8- or 16-bit port always finds its byte on top
    wire [7:0] wb = cur_nxt.wdata[7:0];
    wire [15:0] ww = cur_nxt.wdata[15:0];
    assign dout_nxt = (cur_nxt.size == SZ_BYTE) ? {4{wb}} :
                      ((cur_nxt.size == SZ_WORD) ? {2{ww}} :
                      cur_nxt.wdata);
    assign doe_nxt = ~(acc_nxt & cur_nxt.write);

    // Read capture picks the first lane used, lane 0 being D[31:24]
    wire [4:0] sh = {~lane_cur, 3'h0};
    wire [DATA_W-1:0] rd_sh = data_in >> sh;
    wire [DATA_W-1:0] rd_word = lane_cur[1] ? {16'h0000, data_in[15:0]} :
                                {16'h0000, data_in[31:16]};
    wire [DATA_W-1:0] rd_sel =
        (cur_r.size == SZ_BYTE) ? {24'h00_0000, rd_sh[7:0]} :
        ((cur_r.size == SZ_WORD) ? rd_word : data_in);
    wire col_end = (state_r == ST_COL) & last;
    assign rdata_nxt = (col_end & ~cur_r.write) ? rd_sel : rdata_r;
    assign done_nxt = col_end;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Sequencer and request hold
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_RST;
            pend_r <= 1'b0;
            cur_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            cur_r <= cur_nxt;
        end
    end

    // Strobes and size pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ras_n_r <= RAS_OFF;
            cas_n_r <= CAS_OFF;
            we_n_r <= 1'b1;
            tsize_r <= SZ_LONG;
        end else begin
            ras_n_r <= ras_n_nxt;
            cas_n_r <= cas_n_nxt;
            we_n_r <= we_n_nxt;
            tsize_r <= cur_nxt.size;
        end
    end

    // Address and data pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_r <= ADDR_RST;
            aoe_r <= '1;
            dout_r <= DATA_RST;
            doe_r <= 1'b1;
            rdata_r <= DATA_RST;
            done_r <= 1'b0;
        end else begin
            addr_r <= addr_nxt;
            aoe_r <= aoe_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Optional upper pins drive only when assigned as address
    assign addr_oe_n = aoe_r |
        {~pin_assignment_register, {DED_ADDR_W{1'b0}}};
    assign ras_n = ras_n_r;
    assign cas_n = cas_n_r;
    assign mem_write_strobe_n = we_n_r;
    assign transfer_size = tsize_r;
    assign addr_out = addr_r;
    assign data_out = dout_r;
    assign data_oe_n = doe_r;
    assign rdata = rdata_r;
    assign done = done_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    wire in_acc = (state_r == ST_ROW) | (state_r == ST_COL);
    wire p32 = (bank_port[cur_r.bank] == PORT_32);

    sequence cbr_col_s;
        (state_r == ST_RCAS) && (cas_n_r == 4'h0) && (ras_n_r == RAS_OFF);
    endsequence

    sequence cbr_row_s;
        (state_r == ST_RRAS) && (cas_n_r == 4'h0) && (ras_n_r == 2'h0);
    endsequence

    ras_bank_sel_a: assert property (
        in_acc |-> (ras_n_r[cur_r.bank] == 1'b0) &&
                   (ras_n_r[~cur_r.bank] == 1'b1))
        else $error("row strobe on wrong bank");

    cas_idle_off_a: assert property (
        (idle || state_r == ST_PRE || state_r == ST_ROW) |->
        (cas_n_r == CAS_OFF))
        else $error("column strobe outside column phase");

    cas_byte32_a: assert property (
        (state_r == ST_COL && cur_r.size == SZ_BYTE && p32) |->
        ($countones(~cas_n_r) == 1) && !cas_n_r[cur_r.addr[1:0]])
        else $error("byte lane strobe wrong");

    cas_long32_a: assert property (
        (state_r == ST_COL && p32 && (cur_r.size == SZ_LONG ||
        cur_r.size == SZ_LINE)) |-> (cas_n_r == 4'h0))
        else $error("long word strobes wrong");

    cas_word_a: assert property (
        (state_r == ST_COL && cur_r.size == SZ_WORD && p32) |->
        (cas_n_r == (cur_r.addr[1] ? 4'h3 : 4'hc)))
        else $error("word strobes wrong");

    size_match_a: assert property (
        in_acc |-> (transfer_size == cur_r.size))
        else $error("transfer size differs from operand");

    write_strobe_a: assert property (
        in_acc |-> (mem_write_strobe_n == ~cur_r.write))
        else $error("write strobe wrong in access");

    refresh_we_a: assert property (
        (state_r == ST_RCAS || state_r == ST_RRAS) |-> mem_write_strobe_n)
        else $error("write strobe low in refresh");

    cbr_order_a: assert property (
        $rose(state_r == ST_RCAS) |-> cbr_col_s ##[1:4] cbr_row_s)
        else $error("refresh not column before row");

    row_time_a: assert property (
        $rose(state_r == ST_ROW) |->
        (cnt_r == strobe_timing_register.ras_cas_gap))
        else $error("row phase length not loaded");

    ext_nomux_a: assert property (
        (in_acc && cur_r.ext &&
        !strobe_timing_register.ext_master_addr_mux_enable) |->
        (addr_oe_n == {ADDR_W{1'b1}}))
        else $error("address driven for external master");

    col_addr_a: assert property (
        (state_r == ST_COL && !cur_r.ext) |->
        (addr_out == ADDR_W'(cur_r.addr[COL_SHIFT-1:0])) &&
        (addr_oe_n[DED_ADDR_W-1:0] == '0))
        else $error("column address not on bus");

    upper_pins_a: assert property (
        ((~pin_assignment_register &
        ~addr_oe_n[ADDR_W-1:DED_ADDR_W]) == 4'h0))
        else $error("unassigned upper pin driven");

endmodule

/* dv/dsld_dram_model.sv */
/*
 * Behavioural DRAM pair on the shared data bus.
 * Assumes active-low strobes; reads sample the bus in column cycles.
 */
`timescale 1ns/10ps
module dsld_dram_model #(
    parameter logic [31:0] PAT = 32'hc3a5_5a3c
) (
    input wire logic clk,
    input wire logic [1:0] ras_n,
    input wire logic [3:0] cas_n,
    input wire logic we_n,
    output logic [31:0] data_in
);
    // ------------------------------------------------------------
    // Read drive
    // ------------------------------------------------------------
    logic [31:0] last_r = 32'h0000_0000;
    wire logic rd_act;
    // All four lanes wired as a 32-bit bank on D[31:0]
    assign rd_act = (ras_n != 2'h3) && (cas_n != 4'hf) && we_n;
    // Released bus shows a changing value, never the last data
    assign data_in = rd_act ? PAT : ~last_r;
    always_ff @(posedge clk) begin
        last_r <= data_in;
    end
endmodule

/* dv/dsld_strobe_ctrl_tb.sv */
/*
 * Self-checking bench of the strobe sequencer.
 * Assumes the DRAM model in dsld_dram_model and a 40 MHz clock.
 */
`timescale 1ns/10ps
module dsld_strobe_ctrl_tb;
    import dsld_pkg::*;
    // ------------------------------------------------------------
    // Signals and captures
    // ------------------------------------------------------------
    logic clk, rstn, req_valid, req_ready, refresh_req, done, we_n, d_oe_n;
    dsld_req_t req;
    dsld_port_t [NUM_BANKS-1:0] bank_port;
    dsld_timing_t tim;
    logic [OPT_ADDR_W-1:0] pin_asg;
    logic [DATA_W-1:0] rdata, data_out, data_in;
    logic [NUM_BANKS-1:0] ras_n;
    logic [CAS_LANES-1:0] cas_n;
    logic [1:0] tsize, c_ras, c_sz;
    logic [ADDR_W-1:0] addr_out, addr_oe_n, c_row, c_col, c_oe;
    logic [3:0] c_cas;
    logic [31:0] c_dout;
    logic c_we, c_doe;
    int n_fail, check_count, c_done;

    dsld_strobe_ctrl dut (.clk(clk), .rstn(rstn), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .bank_port(bank_port),
        .strobe_timing_register(tim), .pin_assignment_register(pin_asg),
        .refresh_req(refresh_req), .done(done), .rdata(rdata),
        .ras_n(ras_n), .cas_n(cas_n), .mem_write_strobe_n(we_n),
        .transfer_size(tsize), .addr_out(addr_out),
        .addr_oe_n(addr_oe_n), .data_out(data_out), .data_oe_n(d_oe_n),
        .data_in(data_in));
    dsld_dram_model mem (.clk(clk), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .data_in(data_in));

    // Clock generator
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected active-low column strobes from size, width and A[1:0]
    function automatic logic [3:0] lanes(input logic [1:0] s, p, a);
        logic [3:0] m;
        if (p == 2'h0) m = 4'h1;
        else if (p == 2'h1) m = (s != 2'h1) ? 4'h3 : (a[0] ? 4'h2 : 4'h1);
        else if (s == 2'h1) m = 4'h1 << a;
        else if (s == 2'h2) m = a[1] ? 4'hc : 4'h3;
        else m = 4'hf;
        return ~m;
    endfunction

    // One transfer; records pins per phase for a dozen cycles
    task automatic run(input logic bk, wr, ex, input logic [1:0] sz,
                       input logic [27:0] ad, input logic [31:0] wd);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= {bk, wr, ex, sz, ad, wd};
        @(posedge clk);
        req_valid <= 1'b0;
        c_cas = 4'hf;
        c_ras = 2'h3;
        c_done = 0;
        for (int k = 1; k <= 12; k++) begin
            @(negedge clk);
            if (c_ras == 2'h3 && ras_n != 2'h3) begin
                c_ras = ras_n;
                c_we = we_n;
                c_sz = tsize;
                c_row = addr_out;
                c_oe = addr_oe_n;
                c_dout = data_out;
                c_doe = d_oe_n;
            end
            if (c_cas == 4'hf && cas_n != 4'hf) begin
                c_cas = cas_n;
                c_col = addr_out;
            end
            if (done) c_done = k;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_decode;
        logic [5:0] i;
        for (int n = 0; n < 64; n++) begin
            i = n[5:0];
            if (i[0] && i[5:4] != 2'h1 && i[3:2] != 2'h0) continue;
            if (i[1] && i[5:4] == 2'h0 && i[3]) continue;
            if (i[1] && i[5:4] == 2'h3 && i[3]) continue;
            @(posedge clk);
            bank_port[0] <= dsld_port_t'(i[3:2]);
            run(1'b0, 1'b0, 1'b0, i[5:4], {26'h000_0000, i[1:0]}, 0);
            chk(c_cas, lanes(i[5:4], i[3:2], i[1:0]));
            chk(c_sz, i[5:4]);
            chk(c_ras, 2'h2);
            chk(c_we, 1'b1);
            chk(c_doe, 1'b1);
        end
    endtask

    task automatic t_write;
        @(posedge clk);
        tim <= '{1'b0, 2'h1, 2'h2, 2'h1};
        bank_port[1] <= PORT_32;
        run(1'b1, 1'b1, 1'b0, 2'h1, 28'h00a_5402, 32'h0000_005a);
        chk(c_ras, 2'h1);
        chk(c_we, 1'b0);
        chk(c_done, 6);
        chk(c_cas, 4'hb);
        chk(c_dout, 32'h5a5a_5a5a);
        chk(c_doe, 1'b0);
        chk(c_row, 28'h00a_5402 >> COL_BITS);
        chk(c_col, 32'h0000_0002);
        @(posedge clk);
        tim <= '0;
        bank_port[0] <= PORT_32;
        run(1'b0, 1'b0, 1'b0, 2'h0, 28'h000_0100, 0);
        chk(c_done, 3);
        chk(rdata, 32'hc3a5_5a3c);
        run(1'b0, 1'b0, 1'b0, 2'h1, 28'h000_0101, 0);
        chk(rdata, 32'h0000_00a5);
    endtask

    task automatic t_addr;
        @(posedge clk);
        pin_asg <= 4'h5;
        run(1'b0, 1'b0, 1'b1, 2'h0, 28'h000_0400, 0);
        chk(c_oe[23:0], 32'h00ff_ffff);
        @(posedge clk);
        tim <= '{1'b1, 2'h0, 2'h0, 2'h0};
        run(1'b0, 1'b0, 1'b1, 2'h0, 28'h000_0400, 0);
        chk(c_oe[23:0], 0);
        chk(c_oe[27:24], 4'ha);
        chk(c_row, 28'h000_0001);
    endtask

    task automatic t_refresh;
        logic both, we_ok;
        logic [1:0] ras_at_cas;
        both = 1'b0;
        we_ok = 1'b1;
        ras_at_cas = 2'h0;
        @(posedge clk);
        refresh_req <= 1'b1;
        @(posedge clk);
        refresh_req <= 1'b0;
        for (int k = 0; k < 10; k++) begin
            @(negedge clk);
            if (cas_n != 4'hf && ras_at_cas == 2'h0) ras_at_cas = ras_n;
            if (ras_n == 2'h0 && cas_n == 4'h0) both = 1'b1;
            if (!we_n) we_ok = 1'b0;
            if (k == 0) chk(req_ready, 1'b0);
        end
        chk(ras_at_cas, 2'h3);
        chk(both, 1'b1);
        chk(we_ok, 1'b1);
    endtask

    task automatic wrap_up;
        if (n_fail == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        n_fail = 0;
        check_count = 0;
        rstn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        refresh_req = 1'b0;
        bank_port = '0;
        tim = '0;
        pin_asg = 4'hf;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({ras_n, cas_n, we_n}, 32'h0000_007f);
        @(posedge clk);
        rstn <= 1'b1;
        t_decode();
        t_write();
        t_addr();
        t_refresh();
        wrap_up();
    end

    initial begin
        #(25 * 5000);
        n_fail++;
        wrap_up();
    end
endmodule
